// ===== core/ldad_core.sv
`timescale 1ns/1ns
`default_nettype none
module ldad_core (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Decoded instruction.
  input  wire logic             i_valid,
  input  wire ldad_pkg::ldad_op_t i_op,
  input  wire ldad_pkg::ldad_am_t i_mode,
  input  wire logic [3:0]       i_dst,
  input  wire logic [3:0]       i_base,
  input  wire logic [17:0]      i_offset,
  // Load/store port.
  output logic                  o_mem_req,
  output logic                  o_mem_we,
  output logic [31:0]           o_mem_addr,
  output logic [31:0]           o_mem_wdata,
  input  wire logic             i_mem_ack,
  input  wire logic [31:0]      i_mem_rdata,
  // Status.
  output logic                  o_busy,
  output logic                  o_illegal,
  output logic [31:0]           o_data_reg [16],
  output logic [31:0]           o_addr_reg [16]
);
  import ldad_pkg::*;

  // Sequencer states.
  typedef enum logic [2:0] {
    LDAD_IDLE, LDAD_READ, LDAD_READ_HI, LDAD_WRITE, LDAD_CTX
  } ldad_state_t;

  // All state of the block in one record.
  typedef struct packed {
    ldad_state_t   st;         // Sequencer state.
    ldad_op_t      op;         // Operation in flight.
    logic [3:0]    dst;        // Destination register.
    logic [3:0]    cnt;        // Context word index.
    logic [31:0]   addr;       // Current access address.
    logic [31:0]   lo_word;    // Low word held for doubleword pairs.
    logic          req;        // Memory request.
    logic          we;         // Memory write.
    logic [31:0]   wdata;      // Store data.
    logic          illegal;    // Sticky illegal mode flag.
    logic [15:0][31:0] dreg;   // Data registers.
    logic [15:0][31:0] areg;   // Address registers.
  } ldad_state_rec_t;

  ldad_state_rec_t s_r;  // Registered state.
  ldad_state_rec_t s_nxt; // Next state.

  // Sign extension of a field of given width; bits above the field are ignored.
  function automatic logic [31:0] sext(input logic [17:0] v, input int w);
    logic [31:0] m;  // Sign bit and every bit above it.
    m = 32'hffff_ffff << (w - 1);
    return v[w-1] ? ({14'h0000, v} | m) : ({14'h0000, v} & ~m);
  endfunction
  // Reverse the sixteen bits of an index.
  function automatic logic [15:0] rev16(input logic [15:0] v);
    return {<<{v}};
  endfunction
  // Effective address and base write-back for a mode.
  logic [31:0] ea;         // Access address.
  logic        wb_en;      // Base register is written back.
  logic [3:0]  wb_reg;     // Register written back.
  logic [31:0] wb_val;     // Value written back.
  logic [3:0]  dst_eff;    // Destination after implicit forms.
  logic        mode_ok;    // Mode is legal for the operation.
  logic [31:0] sz;         // Access size in bytes.
  // Access size drives short post-increment and circular stepping.
  always_comb begin
    unique case (i_op)
      LDAD_OP_HALF_SIGNED, LDAD_OP_HALF_UNSIGNED, LDAD_OP_HALF_FRACTION: begin
        sz = 32'h0000_0002;
      end
      LDAD_OP_DWORD_DATA, LDAD_OP_DWORD_ADDR: begin
        sz = 32'h0000_0008;
      end
      default: begin
        sz = 32'h0000_0004;
      end
    endcase
  end

  // Address generation.
  always_comb begin
    logic [31:0] base;
    logic [31:0] idx;
    logic [15:0] nidx;
    base    = s_r.areg[i_base];
    idx     = s_r.areg[i_base | 4'h1];
    nidx    = 16'h0000;
    ea      = base;
    wb_en   = 1'b0;
    wb_reg  = i_base;
    wb_val  = base;
    dst_eff = i_dst;
    unique case (i_mode)
      LDAD_AM_ABS: begin
        ea = {i_offset[17:14], 14'h0000, i_offset[13:0]};
      end
      LDAD_AM_SHORT: begin
        ea = base + sext(i_offset, 10);
      end
      LDAD_AM_LONG: begin
        ea = base + sext(i_offset, 16);
      end
      LDAD_AM_PRE: begin
        ea     = base + sext(i_offset, 10);
        wb_en  = 1'b1;
        wb_val = ea;
      end
      LDAD_AM_POST: begin
        ea     = base;
        wb_en  = 1'b1;
        wb_val = base + sext(i_offset, 10);
      end
      LDAD_AM_CIRC, LDAD_AM_BREV: begin
        // The low register number is forced even, the partner odd.
        ea     = s_r.areg[i_base & 4'he] + {16'h0000, idx[15:0]};
        wb_en  = 1'b1;
        wb_reg = i_base | 4'h1;
        if (i_mode == LDAD_AM_CIRC) begin
          // Index wraps at the length held in the upper half.
          nidx = idx[15:0] + sz[15:0];
          if (nidx >= idx[31:16]) begin
            nidx = nidx - idx[31:16];
          end
        end else begin
          // Bit-reversed increment by the modifier in the upper half.
          nidx = rev16(rev16(idx[15:0]) + rev16(idx[31:16]));
        end
        wb_val = {idx[31:16], nidx};
      end
      LDAD_AM_S_INDIRECT: begin
        ea = base;
      end
      LDAD_AM_S_IMPL_BASE: begin
        ea = s_r.areg[LDAD_IMPLICIT_ADDR_REG] + (sz * {28'h0000000, i_offset[3:0]});
      end
      LDAD_AM_S_IMPL_DEST: begin
        ea      = base + (sz * {28'h0000000, i_offset[3:0]});
        dst_eff = (i_op == LDAD_OP_WORD_ADDR) ? LDAD_IMPLICIT_ADDR_REG
                                              : LDAD_IMPLICIT_DATA_REG;
      end
      LDAD_AM_S_STACK: begin
        ea      = s_r.areg[LDAD_STACK_PTR_REG] + {22'h000000, i_offset[7:0], 2'b00};
        dst_eff = (i_op == LDAD_OP_WORD_ADDR) ? LDAD_IMPLICIT_ADDR_REG
                                              : LDAD_IMPLICIT_DATA_REG;
      end
      LDAD_AM_S_POST: begin
        ea     = base;
        wb_en  = 1'b1;
        wb_val = base + sz;
      end
      default: begin
        ea = base;
      end
    endcase
  end

  // Legal mode per operation.
  always_comb begin
    unique case (i_op)
      LDAD_OP_CTX_LOWER, LDAD_OP_CTX_UPPER: begin
        mode_ok = (i_mode == LDAD_AM_ABS) || (i_mode == LDAD_AM_SHORT);
      end
      LDAD_OP_ADDR_ONLY: begin
        mode_ok = (i_mode == LDAD_AM_ABS) || (i_mode == LDAD_AM_SHORT) ||
                  (i_mode == LDAD_AM_LONG);
      end
      LDAD_OP_WORD_ADDR, LDAD_OP_WORD_DATA: begin
        mode_ok = 1'b1;
      end
      LDAD_OP_HALF_SIGNED, LDAD_OP_HALF_UNSIGNED: begin
        mode_ok = (i_mode != LDAD_AM_LONG) && (i_mode != LDAD_AM_S_STACK);
      end
      default: begin
        mode_ok = (i_mode <= LDAD_AM_BREV) && (i_mode != LDAD_AM_LONG);
      end
    endcase
  end

  // Sequencer. A destination that equals a modified base is not guarded.
  always_comb begin
    logic [3:0] k;
    s_nxt = s_r;
    k     = 4'h0;
    unique case (s_r.st)
      LDAD_IDLE: begin
        if (i_valid) begin
          if (!mode_ok) begin
            s_nxt.illegal = 1'b1;
          end else begin
            s_nxt.op   = i_op;
            s_nxt.dst  = dst_eff;
            s_nxt.addr = ea;
            s_nxt.cnt  = 4'h0;
            if (wb_en) begin
              s_nxt.areg[wb_reg] = wb_val;
            end
            if (i_op == LDAD_OP_ADDR_ONLY) begin
              s_nxt.areg[i_dst] = ea;
            end else begin
              s_nxt.req = 1'b1;
              s_nxt.st  = (i_op == LDAD_OP_CTX_LOWER || i_op == LDAD_OP_CTX_UPPER)
                          ? LDAD_CTX : LDAD_READ;
            end
          end
        end
      end
      LDAD_READ: begin
        if (i_mem_ack) begin
          s_nxt.req = 1'b0;
          unique case (s_r.op)
            LDAD_OP_WORD_ADDR:     s_nxt.areg[s_r.dst] = i_mem_rdata;
            LDAD_OP_WORD_DATA:     s_nxt.dreg[s_r.dst] = i_mem_rdata;
            LDAD_OP_HALF_SIGNED:   s_nxt.dreg[s_r.dst] = sext({2'b00, i_mem_rdata[15:0]}, 16);
            LDAD_OP_HALF_UNSIGNED: s_nxt.dreg[s_r.dst] = {16'h0000, i_mem_rdata[15:0]};
            LDAD_OP_HALF_FRACTION: s_nxt.dreg[s_r.dst] = {i_mem_rdata[15:0], 16'h0000};
            default: begin
            end
          endcase
          s_nxt.st = LDAD_IDLE;
          if (s_r.op == LDAD_OP_DWORD_DATA || s_r.op == LDAD_OP_DWORD_ADDR) begin
            s_nxt.lo_word = i_mem_rdata;
            s_nxt.addr    = s_r.addr + 32'h0000_0004;
            s_nxt.req     = 1'b1;
            s_nxt.st      = LDAD_READ_HI;
          end else if (s_r.op == LDAD_OP_MASKED_STORE) begin
            // Read and write are issued back to back; the memory holds the lock.
            s_nxt.wdata = (i_mem_rdata & ~s_r.dreg[s_r.dst | 4'h1]) |
                          (s_r.dreg[s_r.dst & 4'he] & s_r.dreg[s_r.dst | 4'h1]);
            s_nxt.req   = 1'b1;
            s_nxt.we    = 1'b1;
            s_nxt.st    = LDAD_WRITE;
          end
        end
      end
      LDAD_READ_HI: begin
        if (i_mem_ack) begin
          s_nxt.req = 1'b0;
          s_nxt.st  = LDAD_IDLE;
          if (s_r.op == LDAD_OP_DWORD_DATA) begin
            s_nxt.dreg[s_r.dst & 4'he] = s_r.lo_word;
            s_nxt.dreg[s_r.dst | 4'h1] = i_mem_rdata;
          end else begin
            s_nxt.areg[s_r.dst & 4'he] = s_r.lo_word;
            s_nxt.areg[s_r.dst | 4'h1] = i_mem_rdata;
          end
        end
      end
      LDAD_WRITE: begin
        if (i_mem_ack) begin
          s_nxt.req = 1'b0;
          s_nxt.we  = 1'b0;
          s_nxt.st  = LDAD_IDLE;
        end
      end
      LDAD_CTX: begin
        // Words 0-1 dropped, 2-3 A pair, 4-7 D, 8-11 A, 12-15 D.
        if (i_mem_ack) begin
          k = s_r.cnt;
          if (k >= 4'h2) begin
            unique case (k[3:2])
              2'b00: k = k - 4'h2 + ((s_r.op == LDAD_OP_CTX_LOWER) ? LDAD_CTX_LOWER_A : LDAD_CTX_UPPER_A);
              2'b01: k = k - 4'h4 + ((s_r.op == LDAD_OP_CTX_LOWER) ? LDAD_CTX_LOWER_D : LDAD_CTX_UPPER_D);
              2'b10: k = k - 4'h6 + ((s_r.op == LDAD_OP_CTX_LOWER) ? LDAD_CTX_LOWER_A : LDAD_CTX_UPPER_A);
              default: k = k - 4'h8 + ((s_r.op == LDAD_OP_CTX_LOWER) ? LDAD_CTX_LOWER_D : LDAD_CTX_UPPER_D);
            endcase
            if (s_r.cnt[2]) begin
              s_nxt.dreg[k] = i_mem_rdata;
            end else begin
              s_nxt.areg[k] = i_mem_rdata;
            end
          end
          s_nxt.cnt  = s_r.cnt + 4'h1;
          s_nxt.addr = s_r.addr + 32'h0000_0004;
          if (s_r.cnt == LDAD_CTX_WORDS) begin
            s_nxt.req = 1'b0;
            s_nxt.st  = LDAD_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = LDAD_IDLE;
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_r         <= '0;
      s_r.st      <= LDAD_IDLE;
      s_r.dreg    <= {16{LDAD_REG_RST}};
      s_r.areg    <= {16{LDAD_REG_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state record.
  assign o_mem_req   = s_r.req;
  assign o_mem_we    = s_r.we;
  assign o_mem_addr  = s_r.addr;
  assign o_mem_wdata = s_r.wdata;
  assign o_busy      = (s_r.st != LDAD_IDLE);
  assign o_illegal   = s_r.illegal;
  always_comb begin
    for (int r = 0; r < 16; r++) begin
      o_data_reg[r] = s_r.dreg[r];
      o_addr_reg[r] = s_r.areg[r];
    end
  end
endmodule
`default_nettype wire

// ===== core/ldad_pkg.sv
package ldad_pkg;
  // Operation codes presented by the decoder.
  typedef enum logic [3:0] {
    LDAD_OP_WORD_ADDR,      // Word into an address register.
    LDAD_OP_WORD_DATA,      // Word into a data register.
    LDAD_OP_HALF_SIGNED,    // Signed halfword.
    LDAD_OP_HALF_UNSIGNED,  // Unsigned halfword.
    LDAD_OP_HALF_FRACTION,  // Halfword into the upper half.
    LDAD_OP_DWORD_DATA,     // Doubleword into an extended data register.
    LDAD_OP_DWORD_ADDR,     // Doubleword into an address pair.
    LDAD_OP_CTX_LOWER,      // Lower context restore.
    LDAD_OP_CTX_UPPER,      // Upper context restore.
    LDAD_OP_MASKED_STORE,   // Atomic masked load-modify-store.
    LDAD_OP_ADDR_ONLY       // Address computation only.
  } ldad_op_t;

  // Addressing modes.
  typedef enum logic [3:0] {
    LDAD_AM_ABS,            // Fixed address from an 18-bit offset.
    LDAD_AM_SHORT,          // Base plus 10-bit offset.
    LDAD_AM_LONG,           // Base plus 16-bit offset.
    LDAD_AM_PRE,            // Pre-increment.
    LDAD_AM_POST,           // Post-increment.
    LDAD_AM_CIRC,           // Circular.
    LDAD_AM_BREV,           // Bit-reverse.
    LDAD_AM_S_INDIRECT,     // Short register indirect.
    LDAD_AM_S_IMPL_BASE,    // Short implicit base plus scaled offset.
    LDAD_AM_S_IMPL_DEST,    // Short implicit destination plus scaled offset.
    LDAD_AM_S_STACK,        // Short stack pointer plus 8-bit scaled offset.
    LDAD_AM_S_POST          // Short post-increment.
  } ldad_am_t;

  // Implicit registers of the short encodings.
  localparam logic [3:0] LDAD_IMPLICIT_ADDR_REG = 4'hf;
  localparam logic [3:0] LDAD_IMPLICIT_DATA_REG = 4'hf;
  localparam logic [3:0] LDAD_STACK_PTR_REG     = 4'ha;
  // Context restore block length and register bases.
  localparam logic [3:0] LDAD_CTX_WORDS     = 4'hf;  // Last word index.
  localparam logic [3:0] LDAD_CTX_LOWER_A   = 4'h2;
  localparam logic [3:0] LDAD_CTX_UPPER_A   = 4'ha;
  localparam logic [3:0] LDAD_CTX_LOWER_D   = 4'h0;
  localparam logic [3:0] LDAD_CTX_UPPER_D   = 4'h8;
  // Reset value of the register files.
  localparam logic [31:0] LDAD_REG_RST = 32'h0000_0000;
endpackage

// ===== verif/ldad_core_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Ties the first access address to the instruction that the core took, for the absolute, offset, increment, circular and bit-reverse modes.
module ldad_core_checker (
  // Clock, reset and instruction.
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_valid,
  input  wire ldad_pkg::ldad_op_t i_op,
  input  wire ldad_pkg::ldad_am_t i_mode,
  input  wire logic [3:0]        i_dst,
  input  wire logic [3:0]        i_base,
  input  wire logic [17:0]       i_offset,
  // Port and status.
  input  wire logic              o_mem_req,
  input  wire logic [31:0]       o_mem_addr,
  input  wire logic              o_busy,
  input  wire logic              o_illegal,
  input  wire logic [31:0]       o_addr_reg [16]
);
  import ldad_pkg::*;
  logic        take;    // Instruction accepted at this edge.
  logic        plain;   // Not a context restore nor address-only.
  logic [31:0] ea_q;    // Expected address of the accepted instruction.
  logic [31:0] base_q;  // Base register value at acceptance.
  logic [3:0]  dst_q;   // Destination of the accepted instruction.
  assign take = i_valid && !o_busy;
  assign plain = !(i_op inside {LDAD_OP_CTX_LOWER, LDAD_OP_CTX_UPPER, LDAD_OP_ADDR_ONLY});
  // Snapshot only on acceptance, so multi-word transfers compare to a steady value.
  always_ff @(posedge i_clk) begin
    if (take) begin
      dst_q <= i_dst;
      base_q <= o_addr_reg[i_base];
      case (i_mode)
        LDAD_AM_ABS: ea_q <= {i_offset[17:14], 14'h0, i_offset[13:0]};
        LDAD_AM_LONG: ea_q <= o_addr_reg[i_base] + {{16{i_offset[15]}}, i_offset[15:0]};
        LDAD_AM_CIRC, LDAD_AM_BREV: ea_q <= o_addr_reg[{i_base[3:1], 1'b0}]
          + {16'h0, o_addr_reg[{i_base[3:1], 1'b1}][15:0]};
        default: ea_q <= o_addr_reg[i_base] + {{22{i_offset[9]}}, i_offset[9:0]};
      endcase
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_abs_addr: assert property (
    take && i_mode == LDAD_AM_ABS && i_op != LDAD_OP_ADDR_ONLY |=> o_mem_req && o_mem_addr == ea_q)
    else $error("fixed address wrong");
  a_short_addr: assert property (
    take && i_mode == LDAD_AM_SHORT && i_op != LDAD_OP_ADDR_ONLY |=> o_mem_addr == ea_q)
    else $error("short offset address wrong");
  a_pre_addr: assert property (
    take && i_mode == LDAD_AM_PRE && plain |=> o_mem_req && o_mem_addr == ea_q)
    else $error("pre-increment address wrong");
  a_post_addr: assert property (
    take && i_mode == LDAD_AM_POST && plain |=> o_mem_req && o_mem_addr == base_q)
    else $error("post-increment address wrong");
  a_long_addr: assert property (
    take && i_mode == LDAD_AM_LONG && i_op == LDAD_OP_WORD_DATA |=> o_mem_addr == ea_q)
    else $error("long offset address wrong");
  a_circ_addr: assert property (
    take && i_mode inside {LDAD_AM_CIRC, LDAD_AM_BREV} && plain |=> o_mem_addr == ea_q)
    else $error("circular address wrong");
  a_lea_only: assert property (
    take && i_op == LDAD_OP_ADDR_ONLY && i_mode inside {LDAD_AM_ABS, LDAD_AM_SHORT, LDAD_AM_LONG}
    |=> !o_mem_req && o_addr_reg[dst_q] == ea_q)
    else $error("address-only result wrong");
  a_ctx_mode: assert property (
    take && !plain && i_op != LDAD_OP_ADDR_ONLY && !(i_mode inside {LDAD_AM_ABS, LDAD_AM_SHORT})
    |=> !o_mem_req && o_illegal)
    else $error("context restore mode not refused");
endmodule
`default_nettype wire

// ===== verif/ldad_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// Data memory behind the load/store port, with a settable number of wait states.
module ldad_mem_model (
  // Clock.
  input  wire logic        i_clk,
  // Request from the core.
  input  wire logic        i_req,
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_wait,
  // Answer to the core.
  output logic             o_ack,
  output logic [31:0]      o_rdata
);
  logic [1:0] cnt_r = 2'h0;  // Wait states spent on the current access.
  // Read data is only good with ack; it flips every cycle so stale data never matches.
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == i_wait) begin
        o_ack <= 1'b1;
        o_rdata <= {~i_addr[15:0], i_addr[15:0] | 16'h8000};
        cnt_r <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb_ldad_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ldad_core;
  import ldad_pkg::*;
  // Instruction side, driven by the bench.
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_valid = 1'b0;
  ldad_op_t    i_op = LDAD_OP_WORD_DATA;
  ldad_am_t    i_mode = LDAD_AM_ABS;
  logic [3:0]  i_dst = 4'h0;
  logic [3:0]  i_base = 4'h0;
  logic [17:0] i_offset = 18'h0;
  // Port, status and bookkeeping.
  logic        o_mem_req, o_mem_we, i_mem_ack, o_busy, o_illegal;
  logic [31:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
  logic [31:0] o_data_reg [16];
  logic [31:0] o_addr_reg [16];
  logic [1:0]  wait_n = 2'h0;  // Memory wait states.
  logic [31:0] acc_q [$];      // Addresses of finished accesses.
  logic [31:0] wr_q [$];       // Data of finished writes.
  int          bad_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #50 i_clk = ~i_clk;
  ldad_core ldad_core_i (.i_clk, .i_nrst, .i_valid, .i_op, .i_mode, .i_dst, .i_base, .i_offset,
    .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata, .o_busy,
    .o_illegal, .o_data_reg, .o_addr_reg);
  ldad_mem_model ldad_mem_model_i (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
    .i_wait(wait_n), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  // Log finished accesses so that address order can be judged afterwards.
  always @(posedge i_clk) begin
    if (o_mem_req === 1'b1 && i_mem_ack === 1'b1) begin
      acc_q.push_back(o_mem_addr);
      if (o_mem_we === 1'b1) wr_q.push_back(o_mem_wdata);
    end
  end
  // A hung handshake must not stall the run; the sequence needs far fewer cycles.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  // Word that the memory model returns for an address.
  function automatic logic [31:0] mw(input logic [31:0] a);
    return {~a[15:0], a[15:0] | 16'h8000};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One instruction; returns at a falling edge once the core is idle again.
  task automatic issue(input ldad_op_t op, input ldad_am_t md, input logic [3:0] d,
                       input logic [3:0] b, input logic [17:0] off);
    int n;
    n = 0;
    acc_q.delete();
    wr_q.delete();
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_mode <= md;
    i_dst <= d;
    i_base <= b;
    i_offset <= off;
    @(posedge i_clk);
    i_valid <= 1'b0;
    @(negedge i_clk);
    while (o_busy !== 1'b0 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
  endtask
  // Address-only forms build the base registers that later scenarios use.
  task automatic t_lea();
    issue(LDAD_OP_ADDR_ONLY, LDAD_AM_ABS, 4'h2, 4'h0, 18'h2_8a44);
    chk(o_addr_reg[2], 32'ha000_0a44);
    issue(LDAD_OP_ADDR_ONLY, LDAD_AM_SHORT, 4'h3, 4'h2, 18'h0_03fc);
    chk(o_addr_reg[3], 32'ha000_0a40);
    issue(LDAD_OP_ADDR_ONLY, LDAD_AM_LONG, 4'h4, 4'h2, 18'h0_8000);
    chk(o_addr_reg[4], 32'h9fff_8a44);
    issue(LDAD_OP_ADDR_ONLY, LDAD_AM_ABS, 4'h5, 4'h0, 18'h0_0010);
    issue(LDAD_OP_ADDR_ONLY, LDAD_AM_ABS, 4'h6, 4'h0, 18'h0_1000);
    chk(32'(acc_q.size()), 32'h0);
  endtask
  // Offset and increment modes, a short post-increment, circular and bit-reverse.
  task automatic t_word();
    issue(LDAD_OP_WORD_DATA, LDAD_AM_PRE, 4'h1, 4'h6, 18'h0_0008);
    chk(acc_q[0], 32'h0000_1008);
    chk(o_addr_reg[6], 32'h0000_1008);
    chk(o_data_reg[1], mw(32'h0000_1008));
    issue(LDAD_OP_WORD_DATA, LDAD_AM_POST, 4'h1, 4'h6, 18'h0_03f8);
    chk(acc_q[0], 32'h0000_1008);
    chk(o_addr_reg[6], 32'h0000_1000);
    issue(LDAD_OP_WORD_DATA, LDAD_AM_S_POST, 4'h9, 4'h6, 18'h0);
    chk(acc_q[0], 32'h0000_1000);
    chk(o_addr_reg[6], 32'h0000_1004);
    issue(LDAD_OP_WORD_ADDR, LDAD_AM_SHORT, 4'h8, 4'h6, 18'h0_0200);
    chk(acc_q[0], 32'h0000_0e04);
    chk(o_addr_reg[8], mw(32'h0000_0e04));
    issue(LDAD_OP_WORD_DATA, LDAD_AM_LONG, 4'h8, 4'h6, 18'h0_fffc);
    chk(acc_q[0], 32'h0000_1000);
    issue(LDAD_OP_WORD_DATA, LDAD_AM_CIRC, 4'h7, 4'h4, 18'h0);
    chk(acc_q[0], 32'h9fff_8a54);
    chk(o_addr_reg[5], 32'h0000_0014);
    issue(LDAD_OP_WORD_DATA, LDAD_AM_BREV, 4'h7, 4'h4, 18'h0);
    chk(acc_q[0], 32'h9fff_8a58);
  endtask
  // The fetched halfword has its top bit set, so extension shows.
  task automatic t_half();
    ldad_op_t    ops [3] = '{LDAD_OP_HALF_SIGNED, LDAD_OP_HALF_UNSIGNED, LDAD_OP_HALF_FRACTION};
    logic [31:0] exp [3] = '{32'hffff_8200, 32'h0000_8200, 32'h8200_0000};
    for (int i = 0; i < 3; i++) begin
      issue(ops[i], LDAD_AM_ABS, 4'h2, 4'h0, 18'h0_0200);
      chk(o_data_reg[2], exp[i]);
    end
    issue(LDAD_OP_WORD_DATA, LDAD_AM_S_STACK, 4'h0, 4'h0, 18'h0_0040);
    chk(o_data_reg[15], mw(32'h0000_0100));
    issue(LDAD_OP_HALF_SIGNED, LDAD_AM_S_IMPL_DEST, 4'h2, 4'h6, 18'h0_0001);
    chk(o_data_reg[15], 32'hffff_9006);
    issue(LDAD_OP_HALF_SIGNED, LDAD_AM_S_IMPL_BASE, 4'h3, 4'h0, 18'h0_0003);
    chk(o_data_reg[3], 32'hffff_8006);
    issue(LDAD_OP_HALF_SIGNED, LDAD_AM_S_INDIRECT, 4'h3, 4'h6, 18'h0);
    chk(o_data_reg[3], 32'hffff_9004);
  endtask
  // Pairs and the masked store, against a memory with wait states.
  task automatic t_dword();
    logic [31:0] v;
    v = (mw(32'h400) & ~mw(32'h304)) | (mw(32'h300) & mw(32'h304));
    @(posedge i_clk);
    wait_n <= 2'h2;
    issue(LDAD_OP_DWORD_DATA, LDAD_AM_ABS, 4'h2, 4'h0, 18'h0_0300);
    chk(o_data_reg[2], mw(32'h300));
    chk(o_data_reg[3], mw(32'h304));
    issue(LDAD_OP_DWORD_ADDR, LDAD_AM_ABS, 4'h8, 4'h0, 18'h0_0300);
    chk(o_addr_reg[8], mw(32'h300));
    chk(o_addr_reg[9], mw(32'h304));
    issue(LDAD_OP_MASKED_STORE, LDAD_AM_ABS, 4'h2, 4'h0, 18'h0_0400);
    chk(wr_q[0], v);
    chk(acc_q[1], 32'h400);
    @(posedge i_clk);
    wait_n <= 2'h0;
  endtask
  // Context restore from an aligned block; u selects the upper bank.
  task automatic t_ctx(input ldad_op_t op, input logic [17:0] off, input int u);
    logic [31:0] a;
    issue(op, LDAD_AM_ABS, 4'h0, 4'h0, off);
    for (int i = 2; i < 16; i++) begin
      a = {14'h0, off} + 32'(4 * i);
      if (i < 4 || (i > 7 && i < 12)) chk(o_addr_reg[(i < 4 ? i : i - 4) + u], mw(a));
      else chk(o_data_reg[(i < 8 ? i - 4 : i - 8) + u], mw(a));
    end
  endtask
  // A context restore with an increment mode must be refused without traffic.
  task automatic t_bad();
    issue(LDAD_OP_CTX_LOWER, LDAD_AM_PRE, 4'h0, 4'h6, 18'h0);
    chk({31'h0, o_illegal}, 32'h1);
    chk(32'(acc_q.size()), 32'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Reset for six cycles, then the scenarios; the refusal goes last as its flag is sticky.
  initial begin
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_lea();
    t_word();
    t_half();
    t_dword();
    t_ctx(LDAD_OP_CTX_LOWER, 18'h0_0800, 0);
    t_ctx(LDAD_OP_CTX_UPPER, 18'h0_0c40, 8);
    t_bad();
    print_verdict();
  end
endmodule
bind ldad_core ldad_core_checker ldad_core_checker_i (.i_clk, .i_nrst, .i_valid, .i_op, .i_mode,
  .i_dst, .i_base, .i_offset, .o_mem_req, .o_mem_addr, .o_busy, .o_illegal, .o_addr_reg);
`default_nettype wire
